// ### logic/mtv_axil_slave.sv
// AXI4-Lite slave front end producing register write and read strobes
`timescale 1ns/1ps
module mtv_axil_slave
  import mtv_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output mtv_wr_s          wr,
  output logic             rd_en,
  output logic [7:0]       rd_idx,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);

  // ****************************************
  // Channel holding registers
  // ****************************************
  logic        aw_have_r, aw_have_nxt;   // Write address captured
  logic        w_have_r, w_have_nxt;     // Write data captured
  logic [31:0] aw_addr_r, aw_addr_nxt;   // Captured address
  logic [31:0] w_data_r, w_data_nxt;     // Captured data
  logic        w_lane_r, w_lane_nxt;     // Low byte lane enabled
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        arready_r, arready_nxt;
  logic        awready_r, awready_nxt;   // Address accept pulse
  logic        wready_r, wready_nxt;     // Data accept pulse

  // Next state of both channels
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_lane_nxt  = w_lane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    arready_nxt = 1'b0;
    awready_nxt = 1'b0;
    wready_nxt  = 1'b0;
    wr          = '0;
    rd_en       = 1'b0;
    rd_idx      = s_axi_araddr[9:2];
    // Address and data may arrive in either order; ready is a flopped pulse
    if (s_axi_awvalid && !aw_have_r && !bvalid_r && !awready_r) begin
      awready_nxt = 1'b1;
    end
    if (awready_r && s_axi_awvalid) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_r && !bvalid_r && !wready_r) begin
      wready_nxt = 1'b1;
    end
    if (wready_r && s_axi_wvalid) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_lane_nxt = s_axi_wstrb[0];
    end
    // Both halves held: perform write, raise response
    if (aw_have_r && w_have_r) begin
      wr.en       = w_lane_r && wr_hit;
      wr.idx      = aw_addr_r[9:2];
      wr.data     = w_data_r;
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Read: one cycle accept pulse, data next cycle
    if (s_axi_arvalid && !rvalid_r && !arready_r) begin
      arready_nxt = 1'b1;
    end
    if (arready_r) begin
      rd_en      = 1'b1;
      rd_idx     = s_axi_araddr[9:2];
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_data;
      rresp_nxt  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Register the channel state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_lane_r  <= w_lane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      arready_r <= arready_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
    end
  end

  // Ready outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_arready = arready_r;

endmodule

// ### logic/mtv_pkg.sv
// Package with register map, field positions and carrier types of the MAC timer block
package mtv_pkg;

  // ****************************************
  // Register word indices (printed offsets are register indices)
  // ****************************************
  localparam logic [7:0] IDX_COMPARE_VALUE       = 8'h94; // Compare byte
  localparam logic [7:0] IDX_OVERFLOW_COUNT_LOW  = 8'ha1; // Overflow count bits 7:0
  localparam logic [7:0] IDX_OVERFLOW_COUNT_MID  = 8'ha2; // Overflow count bits 15:8
  localparam logic [7:0] IDX_OVERFLOW_COUNT_HIGH = 8'ha3; // Overflow count bits 19:16
  localparam logic [7:0] IDX_TIMER_VALUE_LOW     = 8'ha6; // Timer value low byte
  localparam logic [7:0] IDX_TIMER_VALUE_HIGH    = 8'ha7; // Timer value high byte
  localparam logic [7:0] IDX_TIMER_CONFIG        = 8'hc3; // Config and status
  localparam logic [7:0] IDX_PERIOD              = 8'hc4; // Period, 16 bits
  localparam logic [7:0] IDX_IRQ_STATUS          = 8'hc5; // Sticky event bits
  localparam logic [7:0] IDX_IRQ_MASK            = 8'hc6; // Interrupt mask

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_RUN_BIT  = 0; // Run request / run status
  localparam int CFG_COMPARE_SOURCE_SELECT    = 3; // Compare source select
  localparam int CFG_FLAG_BIT = 7; // Compare flag
  localparam int EV_CMP       = 0; // Status bit: compare
  localparam int EV_OVF       = 1; // Status bit: overflow

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int TMR_W = 16;
  localparam int OVF_W = 20;
  localparam int EV_W  = 2;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Timer state
  typedef enum logic {ST_IDLE, ST_RUN} mtv_state_e;

  // One decoded register write
  typedef struct packed {
    logic       en;
    logic [7:0] idx;
    logic [31:0] data;
  } mtv_wr_s;

endpackage

// ### logic/mtv_timer_top.sv
// MAC protocol timer with overflow counter, compare and register file
//
// Notes on behaviour
// - low read returns byte, latches high
// - running high write loads pause delta
// - running low write waits for high write
// - idle high write loads counter 15:8
// - idle low write loads counter 7:0
// - compare event when selected byte matches while running
// - overflow count increments at period reach
// - overflow low read latches mid, high
// - overflow write forces count, adds coincident increment
// - overflow low, mid wait for high
// - select bit chooses high or low byte
// - compare flag sticky, cleared writing zero
// - idle and run states, status readable
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module mtv_timer_top
  import mtv_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  // ****************************************
  // Bus front end
  // ****************************************
  mtv_wr_s     wr;          // Decoded write strobe
  logic        rd_en;       // Read data captured this cycle
  logic [7:0]  rd_idx;      // Read register index
  logic [31:0] rd_data;     // Read mux result
  logic        rd_hit;      // Read address mapped
  logic        wr_hit;      // Write address mapped
  logic [7:0]  wr_idx_pre;  // Pending write index for decode

  mtv_axil_slave u_bus (
    .core_clk      (core_clk),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .rd_en         (rd_en),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit),
    .wr_hit        (wr_hit)
  );

  // Write decode uses the held address; hit computed from it
  assign wr_idx_pre = wr.idx;

  // Map check shared by both directions
  function automatic logic idx_mapped(input logic [7:0] idx);
    case (idx)
      IDX_COMPARE_VALUE, IDX_OVERFLOW_COUNT_LOW, IDX_OVERFLOW_COUNT_MID,
      IDX_OVERFLOW_COUNT_HIGH, IDX_TIMER_VALUE_LOW, IDX_TIMER_VALUE_HIGH,
      IDX_TIMER_CONFIG, IDX_PERIOD, IDX_IRQ_STATUS, IDX_IRQ_MASK: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  assign rd_hit = idx_mapped(rd_idx);
  assign wr_hit = idx_mapped(wr_idx_pre);

  // ****************************************
  // State
  // ****************************************
  mtv_state_e  state_r, state_nxt;       // Idle or run
  logic [15:0] count_r, count_nxt;       // Live timer count
  logic [15:0] delta_r, delta_nxt;       // Remaining pause cycles
  logic [7:0]  low_pend_r, low_pend_nxt; // Held low byte for delta
  logic [7:0]  hi_latch_r, hi_latch_nxt; // High byte latched on low read
  logic [7:0]  cmp_r, cmp_nxt;           // Compare value
  logic        compare_source_select_r, compare_source_select_nxt;       // Compare source select
  logic        cmp_flag_r, cmp_flag_nxt; // Sticky compare flag
  logic [15:0] period_r, period_nxt;     // Period
  logic [19:0] ovf_r, ovf_nxt;           // Overflow counter
  logic [7:0]  ovf_lo_pend_r, ovf_lo_pend_nxt;
  logic [7:0]  ovf_mid_pend_r, ovf_mid_pend_nxt;
  logic [11:0] ovf_latch_r, ovf_latch_nxt; // Mid/high latched on low read
  logic [1:0]  ev_stat_r, ev_stat_nxt;   // Sticky interrupt status
  logic [1:0]  ev_mask_r, ev_mask_nxt;   // Interrupt mask
  logic        irq_r, irq_nxt;
  logic        ovf_inc;                  // Period reached this cycle
  logic        cmp_hit;                  // Compare event this cycle
  logic [7:0]  cmp_src;                  // Selected counter byte
  logic [1:0]  ev_now;                   // Events this cycle
  logic [7:0]  wb;                       // Written low byte

  // ****************************************
  // Timer, compare and overflow logic
  // ****************************************
  always_comb begin
    state_nxt        = state_r;
    count_nxt        = count_r;
    delta_nxt        = delta_r;
    low_pend_nxt     = low_pend_r;
    hi_latch_nxt     = hi_latch_r;
    cmp_nxt          = cmp_r;
    compare_source_select_nxt        = compare_source_select_r;
    cmp_flag_nxt     = cmp_flag_r;
    period_nxt       = period_r;
    ovf_nxt          = ovf_r;
    ovf_lo_pend_nxt  = ovf_lo_pend_r;
    ovf_mid_pend_nxt = ovf_mid_pend_r;
    ovf_latch_nxt    = ovf_latch_r;
    ev_mask_nxt      = ev_mask_r;
    wb               = wr.data[7:0];
    ovf_inc          = 1'b0;

    // Counting; a running pause freezes counting and overflow detect
    case (state_r)
      ST_RUN: begin
        if (delta_r != 16'h0000) begin
          delta_nxt = delta_r - 16'h0001;
        end else if (count_r >= period_r) begin
          count_nxt = 16'h0000;
          ovf_inc   = 1'b1;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end
      ST_IDLE: delta_nxt = 16'h0000;
      default: state_nxt = ST_IDLE;
    endcase
    if (ovf_inc) begin
      ovf_nxt = ovf_r + 20'h00001;
    end

    // Selected byte against compare value
    cmp_src = compare_source_select_r ? count_r[7:0] : count_r[15:8];
    cmp_hit = (state_r == ST_RUN) && (cmp_src == cmp_r);

    // Reads with side effects
    if (rd_en && rd_idx == IDX_TIMER_VALUE_LOW) begin
      hi_latch_nxt = count_r[15:8];
    end
    if (rd_en && rd_idx == IDX_OVERFLOW_COUNT_LOW) begin
      ovf_latch_nxt = ovf_r[19:8];
    end

    // Register writes
    if (wr.en) begin
      case (wr.idx)
        IDX_TIMER_VALUE_LOW: begin
          if (state_r == ST_RUN) begin
            low_pend_nxt = wb;
          end else begin
            count_nxt[7:0] = wb;
          end
        end
        IDX_TIMER_VALUE_HIGH: begin
          if (state_r == ST_RUN) begin
            delta_nxt = {wb, low_pend_r};
          end else begin
            count_nxt[15:8] = wb;
          end
        end
        IDX_COMPARE_VALUE:      cmp_nxt = wb;
        IDX_OVERFLOW_COUNT_LOW: ovf_lo_pend_nxt = wb;
        IDX_OVERFLOW_COUNT_MID: ovf_mid_pend_nxt = wb;
        IDX_OVERFLOW_COUNT_HIGH: begin
          // Coincident increment is folded into the forced value
          ovf_nxt = {wb[3:0], ovf_mid_pend_r, ovf_lo_pend_r}
                    + {19'h00000, ovf_inc};
        end
        IDX_TIMER_CONFIG: begin
          state_nxt = wb[CFG_RUN_BIT] ? ST_RUN : ST_IDLE;
          compare_source_select_nxt = wb[CFG_COMPARE_SOURCE_SELECT];
          if (!wb[CFG_FLAG_BIT]) begin
            cmp_flag_nxt = 1'b0;
          end
        end
        IDX_PERIOD:   period_nxt = wr.data[15:0];
        IDX_IRQ_MASK: ev_mask_nxt = wr.data[1:0];
        default: ;
      endcase
    end

    // Set wins over a same-cycle clear
    if (cmp_hit) begin
      cmp_flag_nxt = 1'b1;
    end

    // Sticky status, write one to clear, set wins
    ev_now      = {ovf_inc, cmp_hit};
    ev_stat_nxt = ev_stat_r;
    if (wr.en && wr.idx == IDX_IRQ_STATUS) begin
      ev_stat_nxt = ev_stat_r & ~wr.data[1:0];
    end
    ev_stat_nxt = ev_stat_nxt | ev_now;
    irq_nxt     = |(ev_stat_nxt & ev_mask_nxt);
  end

  // Register all state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r        <= ST_IDLE;
      count_r        <= 16'h0000;
      delta_r        <= 16'h0000;
      low_pend_r     <= BYTE_RST;
      hi_latch_r     <= BYTE_RST;
      cmp_r          <= BYTE_RST;
      compare_source_select_r        <= 1'b0;
      cmp_flag_r     <= 1'b0;
      period_r       <= PERIOD_RST;
      ovf_r          <= 20'h00000;
      ovf_lo_pend_r  <= BYTE_RST;
      ovf_mid_pend_r <= BYTE_RST;
      ovf_latch_r    <= 12'h000;
      ev_stat_r      <= 2'b00;
      ev_mask_r      <= 2'b00;
      irq_r          <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      count_r        <= count_nxt;
      delta_r        <= delta_nxt;
      low_pend_r     <= low_pend_nxt;
      hi_latch_r     <= hi_latch_nxt;
      cmp_r          <= cmp_nxt;
      compare_source_select_r        <= compare_source_select_nxt;
      cmp_flag_r     <= cmp_flag_nxt;
      period_r       <= period_nxt;
      ovf_r          <= ovf_nxt;
      ovf_lo_pend_r  <= ovf_lo_pend_nxt;
      ovf_mid_pend_r <= ovf_mid_pend_nxt;
      ovf_latch_r    <= ovf_latch_nxt;
      ev_stat_r      <= ev_stat_nxt;
      ev_mask_r      <= ev_mask_nxt;
      irq_r          <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      IDX_TIMER_VALUE_LOW:     rd_data[7:0] = count_r[7:0];
      IDX_TIMER_VALUE_HIGH:    rd_data[7:0] = hi_latch_r;
      IDX_COMPARE_VALUE:       rd_data[7:0] = cmp_r;
      IDX_OVERFLOW_COUNT_LOW:  rd_data[7:0] = ovf_r[7:0];
      IDX_OVERFLOW_COUNT_MID:  rd_data[7:0] = ovf_latch_r[7:0];
      IDX_OVERFLOW_COUNT_HIGH: rd_data[3:0] = ovf_latch_r[11:8];
      IDX_TIMER_CONFIG: begin
        rd_data[CFG_FLAG_BIT] = cmp_flag_r;
        rd_data[CFG_COMPARE_SOURCE_SELECT]    = compare_source_select_r;
        rd_data[CFG_RUN_BIT]  = (state_r == ST_RUN);
      end
      IDX_PERIOD:     rd_data[15:0] = period_r;
      IDX_IRQ_STATUS: rd_data[1:0]  = ev_stat_r;
      IDX_IRQ_MASK:   rd_data[1:0]  = ev_mask_r;
      default: ;
    endcase
  end

endmodule

// ### testbench/mtv_timer_top_props.sv
// Bus handshake and read-data checker for the MAC timer top
`timescale 1ns/1ps
module mtv_timer_props
  import mtv_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  // ****************************************
  // Clocking and read walk steps
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Address offered but not yet taken
  sequence ar_wait_s;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  // Address taken this cycle
  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held longer than one cycle");
  aw_cause_a: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("awready without awvalid");
  wr_resp_a: assert property (s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid not released");
  ar_take_a: assert property (ar_wait_s |=> s_axi_arready)
    else $error("read address not taken next cycle");
  r_follow_a: assert property (ar_take_s |=> s_axi_rvalid)
    else $error("read data late");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid not released");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("read data upper bits set");
  r_slverr_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
endmodule

bind mtv_timer_top mtv_timer_props u_mtv_timer_props (.*);

// ### testbench/tb_top.sv
// Self-checking bench for the MAC timer register block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
  import mtv_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_d;
  int          errors = 0, comparisons = 0;
  localparam logic [7:0]  CMPV [4] = '{8'h12, 8'h34, 8'h34, 8'h12};
  localparam logic        SEL [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic        HIT [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic [15:0] PER [3] = '{16'h0, 16'h3, 16'h7};
  localparam logic [19:0] OV0 [3] = '{20'hfffff, 20'h0, 20'h0};
  localparam logic [7:0]  RIDX [6] = '{IDX_COMPARE_VALUE, IDX_OVERFLOW_COUNT_LOW,
    IDX_OVERFLOW_COUNT_MID, IDX_OVERFLOW_COUNT_HIGH, IDX_TIMER_VALUE_LOW, IDX_TIMER_VALUE_HIGH};

  mtv_timer_top u_mtv_timer_top (.*);

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // ****************************************
  // Bus tasks
  // ****************************************
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr  <= {22'h0, idx, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      rsp = s_axi_bresp;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) errors++;
  endtask

  // Read: result lands in rd_d and rsp
  task automatic rd(input logic [7:0] idx);
    int n;
    @(posedge core_clk);
    s_axi_araddr  <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rd_d = s_axi_rdata;
      rsp  = s_axi_rresp;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) errors++;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
    rd(idx);
    `CHK(rd_d, e)
  endtask

  // Low byte first so the high byte comes from the latch
  task automatic get_cnt(output logic [15:0] c);
    rd(IDX_TIMER_VALUE_LOW);
    c[7:0] = rd_d[7:0];
    rd(IDX_TIMER_VALUE_HIGH);
    c[15:8] = rd_d[7:0];
  endtask

  task automatic get_ovf(output logic [19:0] o);
    rd(IDX_OVERFLOW_COUNT_LOW);
    o[7:0] = rd_d[7:0];
    rd(IDX_OVERFLOW_COUNT_MID);
    o[15:8] = rd_d[7:0];
    rd(IDX_OVERFLOW_COUNT_HIGH);
    o[19:16] = rd_d[3:0];
  endtask

  task automatic stop_test;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [15:0] c;
    logic [15:0] cnt [2];
    logic [19:0] o;
    logic [31:0] nrun [3];
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    foreach (RIDX[i]) rchk(RIDX[i], 32'h0);
    rchk(IDX_TIMER_CONFIG, 32'h0);
    // Idle loads and the high-byte latch
    wr(IDX_TIMER_VALUE_HIGH, 32'h12);
    wr(IDX_TIMER_VALUE_LOW, 32'h34);
    rchk(IDX_TIMER_VALUE_LOW, 32'h34);
    wr(IDX_TIMER_VALUE_HIGH, 32'h55);
    rchk(IDX_TIMER_VALUE_HIGH, 32'h12);
    rchk(IDX_TIMER_VALUE_LOW, 32'h34);
    rchk(IDX_TIMER_VALUE_HIGH, 32'h55);
    // Compare source, sticky flag, status and interrupt
    for (int i = 0; i < 4; i++) begin
      wr(IDX_TIMER_VALUE_HIGH, 32'h12);
      wr(IDX_TIMER_VALUE_LOW, 32'h34);
      wr(IDX_COMPARE_VALUE, {24'h0, CMPV[i]});
      wr(IDX_TIMER_CONFIG, {28'h0, SEL[i], 3'b001});
      wr(IDX_TIMER_CONFIG, {24'h0, 1'b1, 3'h0, SEL[i], 3'b000});
      rchk(IDX_TIMER_CONFIG, {24'h0, HIT[i], 3'h0, SEL[i], 3'h0});
      rchk(IDX_IRQ_STATUS, {31'h0, HIT[i]});
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      `CHK(irq, HIT[i])
      wr(IDX_IRQ_STATUS, 32'h3);
      wr(IDX_TIMER_CONFIG, {28'h0, SEL[i], 3'b000});
      rchk(IDX_TIMER_CONFIG, {28'h0, SEL[i], 3'b000});
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MASK, 32'h0);
    end
    // Running: low write waits, high write starts a pause
    for (int i = 0; i < 2; i++) begin
      wr(IDX_TIMER_VALUE_HIGH, 32'h0);
      wr(IDX_TIMER_VALUE_LOW, 32'h0);
      wr(IDX_TIMER_CONFIG, 32'h1);
      wr(IDX_TIMER_VALUE_LOW, 32'h10);
      wr(i ? IDX_TIMER_VALUE_HIGH : IDX_COMPARE_VALUE, 32'h0);
      repeat (30) @(posedge core_clk);
      wr(IDX_TIMER_CONFIG, 32'h0);
      get_cnt(cnt[i]);
    end
    `CHK(cnt[1] + 16'h10, cnt[0])
    // Overflow count: pending bytes, latch, unused bits
    wr(IDX_OVERFLOW_COUNT_LOW, 32'h21);
    wr(IDX_OVERFLOW_COUNT_MID, 32'h43);
    rchk(IDX_OVERFLOW_COUNT_LOW, 32'h0);
    rchk(IDX_OVERFLOW_COUNT_MID, 32'h0);
    wr(IDX_OVERFLOW_COUNT_HIGH, 32'hf5);
    rchk(IDX_OVERFLOW_COUNT_LOW, 32'h21);
    wr(IDX_OVERFLOW_COUNT_LOW, 32'h0);
    wr(IDX_OVERFLOW_COUNT_MID, 32'h0);
    wr(IDX_OVERFLOW_COUNT_HIGH, 32'h0);
    rchk(IDX_OVERFLOW_COUNT_MID, 32'h43);
    rchk(IDX_OVERFLOW_COUNT_HIGH, 32'h05);
    // Same run length under three periods, one with a wrap
    for (int i = 0; i < 3; i++) begin
      wr(IDX_PERIOD, {16'h0, PER[i]});
      wr(IDX_TIMER_VALUE_HIGH, 32'h0);
      wr(IDX_TIMER_VALUE_LOW, 32'h0);
      wr(IDX_OVERFLOW_COUNT_LOW, {24'h0, OV0[i][7:0]});
      wr(IDX_OVERFLOW_COUNT_MID, {24'h0, OV0[i][15:8]});
      wr(IDX_OVERFLOW_COUNT_HIGH, {24'h0, 4'hf, OV0[i][19:16]});
      wr(IDX_TIMER_CONFIG, 32'h1);
      repeat (40) @(posedge core_clk);
      wr(IDX_TIMER_CONFIG, 32'h0);
      get_cnt(c);
      get_ovf(o);
      `CHK(c <= PER[i], 1'b1)
      o = o - OV0[i];
      nrun[i] = 32'(o) * (32'(PER[i]) + 32'h1) + 32'(c);
    end
    `CHK(nrun[0] > 32'd40, 1'b1)
    `CHK(nrun[1], nrun[0])
    `CHK(nrun[2], nrun[0])
    // Unmapped place refused
    rd(8'h10);
    `CHK(rsp, RESP_SLVERR)
    `CHK(rd_d, 32'h0)
    wr(8'h10, 32'h1);
    `CHK(rsp, RESP_SLVERR)
    stop_test();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #100us;
    errors++;
    stop_test();
  end
endmodule
